// file: rtl/ref_ladder_dac_control.sv
// Register slave and routing logic for the 32-level reference ladder
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module ref_ladder_dac_control (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Ladder analog control
   output ref_ladder_pkg::ladder_drive_s ladder_drive,
   output logic [5:0] cmp_ref_tap,
   output logic [5:0] adc_ref_tap,
   output logic cmp_ref_valid,
   output logic adc_ref_valid,
   // Port logic side of the two output pins
   input wire logic [1:0] port_out,
   input wire logic [1:0] port_oe_n,
   output logic [1:0] port_read,
   // Pad side of the two output pins
   input wire logic [1:0] pad_in,
   output ref_ladder_pkg::pad_ctl_s [1:0] pad_ctl
);
   import ref_ladder_pkg::*;

   logic ack_r;
   logic [31:0] readdata_r;
   logic [7:0] ctrl_first_r;
   logic [4:0] level_r;
   logic park_r;
   ladder_drive_s drive_r;
   ladder_drive_s drive_nxt;
   logic [5:0] cmp_tap_r;
   logic [5:0] adc_tap_r;
   logic cmp_valid_r;
   logic adc_valid_r;
   logic [1:0] route;
   logic [1:0] port_read_r;
   pad_ctl_s [1:0] pad_r;
   logic req;
   logic wr_acc;
   logic lane0;

   // One wait state per access
   assign req = read | write;
   assign waitrequest = req & ~ack_r;
   assign wr_acc = write & ack_r;
   assign lane0 = byteenable[0];

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // Read data captured in the wait cycle, stands at the accepting edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         readdata_r <= 32'h0000_0000;
      end else if (read & ~ack_r) begin
         if (address == ADDR_CTRL_FIRST) begin
            readdata_r <= {24'h00_0000, ctrl_first_r & CTRL_FIRST_MASK};
         end else if (address == ADDR_CTRL_SECOND) begin
            readdata_r <= {27'h000_0000, level_r};
         end else if (address == ADDR_PARK) begin
            readdata_r <= {31'h0000_0000, park_r};
         end else begin
            readdata_r <= 32'h0000_0000;
         end
      end
   end
   assign readdata = readdata_r;

   // Control registers change only by bus write or reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_first_r <= CTRL_FIRST_RST;
      end else if (wr_acc && lane0 && address == ADDR_CTRL_FIRST) begin
         ctrl_first_r <= writedata[7:0] & CTRL_FIRST_MASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         level_r <= LEVEL_RST;
      end else if (wr_acc && lane0 && address == ADDR_CTRL_SECOND) begin
         level_r <= writedata[LEVEL_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         park_r <= PARK_RST;
      end else if (wr_acc && lane0 && address == ADDR_PARK) begin
         park_r <= writedata[BIT_PARK];
      end
   end

   // Ladder tap selection
   always_comb begin
      drive_nxt.ladder_on = ctrl_first_r[BIT_LADDER_ON];
      drive_nxt.pos_source_pick = ctrl_first_r[BIT_POS_SRC];
      if (ctrl_first_r[BIT_LADDER_ON]) begin
         drive_nxt.tap = {1'b0, level_r};
      end else if (park_r && level_r == LEVEL_ALL_ONES) begin
         drive_nxt.tap = TAP_POS;
      end else begin
         drive_nxt.tap = TAP_NEG;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         drive_r <= '0;
      end else begin
         drive_r <= drive_nxt;
      end
   end
   assign ladder_drive = drive_r;

   // Internal reference consumers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cmp_tap_r <= TAP_NEG;
         adc_tap_r <= TAP_NEG;
         cmp_valid_r <= 1'b0;
         adc_valid_r <= 1'b0;
      end else begin
         cmp_tap_r <= drive_nxt.tap;
         adc_tap_r <= drive_nxt.tap;
         cmp_valid_r <= drive_nxt.ladder_on;
         adc_valid_r <= drive_nxt.ladder_on;
      end
   end
   assign cmp_ref_tap = cmp_tap_r;
   assign adc_ref_tap = adc_tap_r;
   assign cmp_ref_valid = cmp_valid_r;
   assign adc_ref_valid = adc_valid_r;

   assign route[0] = ctrl_first_r[BIT_PIN1_REF];
   assign route[1] = ctrl_first_r[BIT_PIN2_REF];

   // Pad override per pin
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         always_ff @(posedge core_clk) begin
            if (rst) begin
               pad_r[gi] <= '{drive_out: 1'b0, drive_oe_n: 1'b1, detector_en: 1'b1, analog_sel: 1'b0};
               port_read_r[gi] <= 1'b0;
            end else if (route[gi]) begin
               pad_r[gi] <= '{drive_out: 1'b0, drive_oe_n: 1'b1, detector_en: 1'b0, analog_sel: 1'b1};
               port_read_r[gi] <= 1'b0;
            end else begin
               pad_r[gi] <= '{drive_out: port_out[gi], drive_oe_n: port_oe_n[gi], detector_en: 1'b1,
                              analog_sel: 1'b0};
               port_read_r[gi] <= pad_in[gi];
            end
         end
      end
   endgenerate
   assign pad_ctl = pad_r;
   assign port_read = port_read_r;

   // Checks
   property p_enable;
      @(posedge core_clk) disable iff (rst)
      (wr_acc && lane0 && address == ADDR_CTRL_FIRST) |-> ##2 ladder_drive.ladder_on == $past(writedata[7], 2);
   endproperty
   a_enable: assert property (p_enable) else $error("ladder enable does not follow write");

   property p_level;
      @(posedge core_clk) disable iff (rst)
      ##1 $past(ctrl_first_r[BIT_LADDER_ON]) |-> ladder_drive.tap == {1'b0, $past(level_r)};
   endproperty
   a_level: assert property (p_level) else $error("enabled tap differs from level code");

   property p_park_hi;
      @(posedge core_clk) disable iff (rst)
      (!ctrl_first_r[BIT_LADDER_ON] && park_r && level_r == LEVEL_ALL_ONES) |=> ladder_drive.tap == TAP_POS;
   endproperty
   a_park_hi: assert property (p_park_hi) else $error("park high not at positive source");

   property p_park_lo;
      @(posedge core_clk) disable iff (rst)
      (!ctrl_first_r[BIT_LADDER_ON] && !park_r && level_r == LEVEL_ALL_ZEROS) |=> ladder_drive.tap == TAP_NEG;
   endproperty
   a_park_lo: assert property (p_park_lo) else $error("park low not at negative source");

   property p_source;
      @(posedge core_clk) disable iff (rst)
      ##1 ladder_drive.pos_source_pick == $past(ctrl_first_r[BIT_POS_SRC]);
   endproperty
   a_source: assert property (p_source) else $error("positive source pick wrong");

   property p_route;
      @(posedge core_clk) disable iff (rst)
      ##1 pad_ctl[0].analog_sel == $past(ctrl_first_r[BIT_PIN1_REF]) &&
         pad_ctl[1].analog_sel == $past(ctrl_first_r[BIT_PIN2_REF]);
   endproperty
   a_route: assert property (p_route) else $error("pin routing wrong");

   property p_override;
      @(posedge core_clk) disable iff (rst)
      route[0] |=> pad_ctl[0].drive_oe_n && !pad_ctl[0].detector_en && !pad_ctl[0].drive_out;
   endproperty
   a_override: assert property (p_override) else $error("pin 1 digital path not overridden");

   property p_read_zero;
      @(posedge core_clk) disable iff (rst)
      route[1] |=> port_read[1] == 1'b0;
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("routed pin read not zero");

   property p_internal;
      @(posedge core_clk) disable iff (rst)
      cmp_ref_tap == ladder_drive.tap && adc_ref_tap == ladder_drive.tap;
   endproperty
   a_internal: assert property (p_internal) else $error("internal reference taps disagree");

   property p_hold;
      @(posedge core_clk) disable iff (rst)
      !(wr_acc && address == ADDR_CTRL_FIRST) |=> $stable(ctrl_first_r);
   endproperty
   a_hold: assert property (p_hold) else $error("first control register changed without write");

   property p_reset;
      @(posedge core_clk)
      rst |=> ctrl_first_r == CTRL_FIRST_RST && level_r == LEVEL_RST && park_r == PARK_RST;
   endproperty
   a_reset: assert property (p_reset) else $error("reset did not clear controls");

   property p_unimpl;
      @(posedge core_clk) disable iff (rst)
      (ctrl_first_r & ~CTRL_FIRST_MASK) == 8'h00;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

   property p_wait;
      @(posedge core_clk) disable iff (rst)
      req |-> ##[0:1] !waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("access not accepted in time");

   // Register writes land one edge after acceptance
   property p_ctrl_write;
      @(posedge core_clk) disable iff (rst)
      (wr_acc && lane0 && address == ADDR_CTRL_FIRST) |=>
         ctrl_first_r == ($past(writedata[7:0]) & CTRL_FIRST_MASK);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("first control write did not land");

   property p_level_write;
      @(posedge core_clk) disable iff (rst)
      (wr_acc && lane0 && address == ADDR_CTRL_SECOND) |=> level_r == $past(writedata[LEVEL_W-1:0]);
   endproperty
   a_level_write: assert property (p_level_write) else $error("level code write did not land");

   property p_park_write;
      @(posedge core_clk) disable iff (rst)
      (wr_acc && lane0 && address == ADDR_PARK) |=> park_r == $past(writedata[BIT_PARK]);
   endproperty
   a_park_write: assert property (p_park_write) else $error("park select write did not land");

   property p_lane_off;
      @(posedge core_clk) disable iff (rst)
      (wr_acc && !lane0) |=> $stable(ctrl_first_r) && $stable(level_r) && $stable(park_r);
   endproperty
   a_lane_off: assert property (p_lane_off) else $error("write without low byte lane changed a register");

   property p_wait_first;
      @(posedge core_clk) disable iff (rst)
      (req && !ack_r) |-> waitrequest;
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("first request cycle not stalled");

   property p_park_other;
      @(posedge core_clk) disable iff (rst)
      (!ctrl_first_r[BIT_LADDER_ON] && !(park_r && level_r == LEVEL_ALL_ONES)) |=> ladder_drive.tap == TAP_NEG;
   endproperty
   a_park_other: assert property (p_park_other) else $error("disabled ladder not at negative source");

   // Consumer taps checked against the registers, not the drive copy
   property p_internal_on;
      @(posedge core_clk) disable iff (rst)
      ##1 $past(ctrl_first_r[BIT_LADDER_ON]) |-> cmp_ref_tap == {1'b0, $past(level_r)} &&
         adc_ref_tap == {1'b0, $past(level_r)} && cmp_ref_valid && adc_ref_valid;
   endproperty
   a_internal_on: assert property (p_internal_on) else $error("internal reference tap wrong");

   property p_ref_off;
      @(posedge core_clk) disable iff (rst)
      ##1 !$past(ctrl_first_r[BIT_LADDER_ON]) |-> !cmp_ref_valid && !adc_ref_valid;
   endproperty
   a_ref_off: assert property (p_ref_off) else $error("internal reference valid while disabled");

   property p_reset_out;
      @(posedge core_clk)
      rst |=> ladder_drive == '0 && port_read == 2'h0 &&
         !pad_ctl[0].analog_sel && !pad_ctl[1].analog_sel;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("reset did not clear outputs");

   property p_route_detect;
      @(posedge core_clk) disable iff (rst)
      !(pad_ctl[0].analog_sel && (pad_ctl[0].detector_en || !pad_ctl[0].drive_oe_n)) &&
         !(pad_ctl[1].analog_sel && (pad_ctl[1].detector_en || !pad_ctl[1].drive_oe_n));
   endproperty
   a_route_detect: assert property (p_route_detect) else $error("analog pin left with digital path");

   property p_override_pin2;
      @(posedge core_clk) disable iff (rst)
      route[1] |=> pad_ctl[1].drive_oe_n && !pad_ctl[1].detector_en && !pad_ctl[1].drive_out;
   endproperty
   a_override_pin2: assert property (p_override_pin2) else $error("pin 2 digital path not overridden");

   property p_read_zero_pin1;
      @(posedge core_clk) disable iff (rst)
      route[0] |=> port_read[0] == 1'b0;
   endproperty
   a_read_zero_pin1: assert property (p_read_zero_pin1) else $error("routed pin 1 read not zero");

   property p_pad_follow;
      @(posedge core_clk) disable iff (rst)
      ##1 (!$past(rst) && !$past(route[0])) |-> pad_ctl[0].drive_out == $past(port_out[0]) &&
         pad_ctl[0].drive_oe_n == $past(port_oe_n[0]) && pad_ctl[0].detector_en;
   endproperty
   a_pad_follow: assert property (p_pad_follow) else $error("unrouted pin 1 not following port");

   property p_read_follow;
      @(posedge core_clk) disable iff (rst)
      ##1 (!$past(rst) && !$past(route[1])) |-> port_read[1] == $past(pad_in[1]);
   endproperty
   a_read_follow: assert property (p_read_follow) else $error("unrouted pin 2 read not following pad");

   c_enabled: cover property (@(posedge core_clk) disable iff (rst) ladder_drive.ladder_on && ladder_drive.tap != TAP_NEG);
   c_park_lo: cover property (@(posedge core_clk) disable iff (rst) !ladder_drive.ladder_on && !park_r && ladder_drive.tap == TAP_NEG);
   c_park_hi: cover property (@(posedge core_clk) disable iff (rst) ladder_drive.tap == TAP_POS);
   c_both_pins: cover property (@(posedge core_clk) disable iff (rst) pad_ctl[0].analog_sel && pad_ctl[1].analog_sel);
   c_read: cover property (@(posedge core_clk) disable iff (rst) read && !waitrequest && address == ADDR_CTRL_FIRST);
endmodule

// file: rtl/ref_ladder_pkg.sv
// Constants and carrier types for the reference ladder control block
package ref_ladder_pkg;
   // Register byte addresses
   localparam logic [3:0] ADDR_CTRL_FIRST = 4'h0;
   localparam logic [3:0] ADDR_CTRL_SECOND = 4'h4;
   localparam logic [3:0] ADDR_PARK = 4'h8;
   // First control register fields
   localparam int BIT_LADDER_ON = 7;
   localparam int BIT_PIN1_REF = 5;
   localparam int BIT_PIN2_REF = 4;
   localparam int BIT_POS_SRC = 2;
   localparam logic [7:0] CTRL_FIRST_MASK = 8'hb4;
   localparam logic [7:0] CTRL_FIRST_RST = 8'h00;
   // Second control register and park register fields
   localparam int LEVEL_W = 5;
   localparam logic [4:0] LEVEL_RST = 5'h00;
   localparam logic [4:0] LEVEL_ALL_ONES = 5'h1f;
   localparam logic [4:0] LEVEL_ALL_ZEROS = 5'h00;
   localparam int BIT_PARK = 0;
   localparam logic PARK_RST = 1'b0;
   // Tap index: 0 is the negative source, 32 the positive source
   localparam int TAP_W = 6;
   localparam logic [5:0] TAP_NEG = 6'h00;
   localparam logic [5:0] TAP_POS = 6'h20;
   localparam int NUM_PINS = 2;

   typedef struct packed {
      logic ladder_on;
      logic pos_source_pick;
      logic [5:0] tap;
   } ladder_drive_s;

   typedef struct packed {
      logic drive_out;
      logic drive_oe_n;
      logic detector_en;
      logic analog_sel;
   } pad_ctl_s;
endpackage

// file: verif/testbench.sv
// Self-checking bench for the reference ladder control block
`timescale 1ns/1ps
module testbench;
   import ref_ladder_pkg::*;
   logic core_clk, rst, read, write;
   logic [3:0] address, byteenable;
   logic [31:0] writedata, readdata, q, lfsr;
   logic waitrequest, cmp_ref_valid, adc_ref_valid;
   ladder_drive_s ladder_drive;
   logic [5:0] cmp_ref_tap, adc_ref_tap;
   logic [1:0] port_out, port_oe_n, port_read, pad_in;
   pad_ctl_s [1:0] pad_ctl;
   int n_errors = 0, checks_done = 0, cycles = 0;
   int m_ctrl = 0, m_level = 0, m_park = 0;
   ref_ladder_dac_control dut (.core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .ladder_drive(ladder_drive), .cmp_ref_tap(cmp_ref_tap), .adc_ref_tap(adc_ref_tap),
      .cmp_ref_valid(cmp_ref_valid), .adc_ref_valid(adc_ref_valid), .port_out(port_out),
      .port_oe_n(port_oe_n), .port_read(port_read), .pad_in(pad_in), .pad_ctl(pad_ctl));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles >= 20000) begin
         n_errors++;
         $display("mismatch timeout expected finish seen hang");
         complete_run();
      end
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h000000c5 : 32'h00000000);
   endfunction
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus_op(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge core_clk);
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= wr;
      read <= ~wr;
      @(posedge core_clk);
      while (waitrequest !== 1'b0) begin
         n++;
         @(posedge core_clk);
      end
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      check("wait_cycles", 32'h0000_0001, n);
      if (wr && be[0] && a == ADDR_CTRL_FIRST) m_ctrl = d[7:0] & 8'hb4;
      if (wr && be[0] && a == ADDR_CTRL_SECOND) m_level = d[4:0];
      if (wr && be[0] && a == ADDR_PARK) m_park = d[0];
   endtask
   task automatic check_reg(input logic [3:0] a);
      int e;
      e = (a == ADDR_CTRL_FIRST) ? m_ctrl : (a == ADDR_CTRL_SECOND) ? m_level : (a == ADDR_PARK) ? m_park : 0;
      bus_op(1'b0, a, 32'h0, 4'hf);
      check("readdata", e, q);
   endtask
   task automatic check_outputs();
      int on, tap, routed;
      on = (m_ctrl >> 7) & 1;
      tap = on ? m_level : ((m_park == 1 && m_level == 31) ? 32 : 0);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      check("ladder_drive", {on[0], m_ctrl[2], tap[5:0]}, ladder_drive);
      check("cmp_ref_tap", tap, cmp_ref_tap);
      check("adc_ref_tap", tap, adc_ref_tap);
      check("ref_valid", {on[0], on[0]}, {cmp_ref_valid, adc_ref_valid});
      for (int i = 0; i < NUM_PINS; i++) begin
         routed = (i == 0) ? m_ctrl[5] : m_ctrl[4];
         if (routed) check("pad_ctl", 4'b0101, pad_ctl[i]);
         else check("pad_ctl", {port_out[i], port_oe_n[i], 2'b10}, pad_ctl[i]);
         check("port_read", routed ? 1'b0 : pad_in[i], port_read[i]);
      end
   endtask
   task automatic check_all();
      check_reg(ADDR_CTRL_FIRST);
      check_reg(ADDR_CTRL_SECOND);
      check_reg(ADDR_PARK);
      check_outputs();
   endtask
   initial begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 4'h0;
      byteenable = 4'h0;
      writedata = 32'h0;
      port_out = 2'b00;
      port_oe_n = 2'b11;
      pad_in = 2'b00;
      lfsr = 32'hc6f9;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      check_all();
      $display("test reset done");
      for (int i = 0; i < 60; i++) begin
         lfsr = lfsr_next(lfsr);
         @(posedge core_clk);
         {port_out, port_oe_n, pad_in} <= lfsr[21:16];
         bus_op(1'b1, (lfsr[1:0] == 2'b11) ? 4'h0 : {lfsr[1:0], 2'b00}, {24'h0, lfsr[15:8]}, 4'h1);
         check_reg(ADDR_CTRL_FIRST);
         check_reg(ADDR_CTRL_SECOND);
         check_outputs();
      end
      $display("test random done");
      for (int k = 0; k < 8; k++) begin
         bus_op(1'b1, ADDR_CTRL_FIRST, {24'h0, k[2], 7'h0}, 4'h1);
         bus_op(1'b1, ADDR_PARK, {31'h0, k[0]}, 4'h1);
         bus_op(1'b1, ADDR_CTRL_SECOND, k[1] ? 32'h1f : 32'h0, 4'h1);
         check_outputs();
      end
      $display("test park done");
      bus_op(1'b1, 4'hc, 32'hff, 4'hf);
      check_reg(4'hc);
      bus_op(1'b1, ADDR_CTRL_FIRST, 32'hff, 4'hf);
      bus_op(1'b1, ADDR_CTRL_FIRST, 32'h00, 4'h0);
      check_reg(ADDR_CTRL_FIRST);
      check_outputs();
      $display("test refused done");
      @(posedge core_clk);
      rst <= 1'b1;
      {port_out, port_oe_n, pad_in} <= 6'b001100;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      m_ctrl = 0;
      m_level = 0;
      m_park = 0;
      check_all();
      $display("test midrun reset done");
      complete_run();
   end
endmodule
